/* wcd_pkg.sv */
// Shared constants and types for the wake-up card presence detector.
// Notes on behaviour
// RL1: Detection mode runs only while the request bit is the sole set control bit.
// RL2: Capacitive, phase and amplitude measurements are each selectable.
// RL3: An interval timer on the 32 kHz RC tick schedules each detection.
// RL4: Enabled measurements repeat each period; a departure from reference interrupts.
// RL5: Phase and amplitude measurements switch the reader field on for about 20 us.
// RL6: Timer configuration selects interval 10 to 800 ms and enabled methods; 100 ms default.
// RL7: Detection configuration and display registers span addresses 32h to 3Eh.
// RL8: Each method owns config, host reference, average display and result display.
// RL9: Interrupt only when reference difference exceeds the programmed threshold.
// RL10: Each method uses either the running average or the host reference.
// RL11: Method config holds threshold, reference source and averaging weight.
// RL12: Host programs configuration before entering the mode and leaves it alone.
// RL13: New average equals old minus (old minus measurement) divided by weight.
// RL14: The running average is kept with 10-bit precision.
// RL15: First average comes from nonzero host reference, else from first measurement.
// RL16: A config bit decides whether triggering measurements enter the average.
// RL17: Measurements are 8-bit converter results, widened to 10 bits for averaging.
// RL18: On expiry run methods in turn, update displays, compare, restart timer.
// RL19: The comparison uses the absolute difference, catching rises and falls.
package wcd_pkg;
  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int RC_HZ = 32_000;
  localparam int FIELD_ON_NS = 20_000;
  localparam int FIELD_CYC = (FIELD_ON_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int STEP_SHORT_MS = 10;
  localparam int STEP_LONG_MS = 100;
  localparam int TICKS_SHORT = RC_HZ * STEP_SHORT_MS / 1000;
  localparam int TICKS_LONG = RC_HZ * STEP_LONG_MS / 1000;
  localparam int TIMER_W = 15;
  localparam int FCNT_W = 10;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_WAKE_TIMER = 8'h32; // RL7
  localparam logic [7:0] REG_METHOD_BASE = 8'h33;
  localparam logic [7:0] REG_METHOD_STRIDE = 8'h04;
  localparam logic [7:0] REG_LAST = 8'h3E; // RL7
  localparam logic [7:0] OPC_DETECT_ONLY = 8'h04;
  localparam int WTC_LONG_BIT = 7;
  localparam int WTC_CODE_LSB = 4;
  localparam logic [7:0] WTC_RESET = 8'h80;
  localparam int CFG_AUTO_BIT = 0;
  localparam int CFG_WEIGHT_LSB = 1;
  localparam int CFG_INCL_BIT = 3;
  localparam int CFG_THR_LSB = 4;
  localparam int NUM_METHODS = 3;
  localparam logic [1:0] M_AMP = 2'h0;
  localparam logic [1:0] M_PHASE = 2'h1;
  localparam logic [1:0] M_CAP = 2'h2;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_PICK = 3'h2,
    ST_FIELD = 3'h3,
    ST_CONV = 3'h4,
    ST_INIT = 3'h5,
    ST_CMP = 3'h6,
    ST_AVG = 3'h7
  } wcd_state_t;
endpackage

/* wcd_interval_timer.sv */
// Interval timer counting RC oscillator ticks between detections.
`timescale 1ns/1ps
module wcd_interval_timer
  import wcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic rcTick,
  input wire logic restart,
  input wire logic longStep,
  input wire logic [2:0] code,
  output logic expire
);
  logic [TIMER_W-1:0] count;
  logic [TIMER_W-1:0] next_count;
  logic next_expire;
  logic [TIMER_W-1:0] target;

  // Period is (code + 1) steps of 10 ms or 100 ms, giving 10 to 800 ms.
  assign target = TIMER_W'((code + 4'h1) * (longStep ? TICKS_LONG : TICKS_SHORT)); // RL6

  // Count ticks and pulse on the last one of the period.
  always_comb begin
    next_count = count;
    next_expire = 1'b0;
    if (restart) begin
      next_count = '0;
    end else if (rcTick) begin // RL3
      if (count == target - 15'h1) begin
        next_count = '0;
        next_expire = 1'b1;
      end else begin
        next_count = count + 15'h1;
      end
    end
  end

  // Registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
      expire <= 1'b0;
    end else if (clkEn) begin
      count <= next_count;
      expire <= next_expire;
    end
  end

  chk_timer_restart: assert property (@(posedge clk) disable iff (!rst_n) // RL18
    (restart && clkEn) |=> (count == '0 && !expire))
    else $error("Timer did not clear on restart.");
  chk_timer_period: assert property (@(posedge clk) disable iff (!rst_n) // RL3
    (expire && $past(clkEn) && $past(rst_n)) |-> ($past(count) == target - 15'h1))
    else $error("Timer expired before the end of the period.");
endmodule

/* wcd_avg_unit.sv */
// Running-average update of a 10-bit reference from an 8-bit measurement.
`timescale 1ns/1ps
module wcd_avg_unit
  import wcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic start,
  input wire logic [9:0] oldRef,
  input wire logic [7:0] meas,
  input wire logic [1:0] weightSel,
  output logic [9:0] newRef,
  output logic done
);
  logic [9:0] next_newRef;
  logic signed [10:0] diff;
  logic [9:0] mag;
  logic [9:0] quot;

  // The measurement is widened to the 10-bit scale of the average.
  assign diff = $signed({1'b0, oldRef}) - $signed({1'b0, meas, 2'h0}); // RL14
  assign mag = diff[10] ? 10'(-diff) : diff[9:0];
  // Weight is 2, 4, 8 or 16; the magnitude is shifted so rounding is toward zero.
  assign quot = mag >> (weightSel + 3'h1);

  // New reference moves from the old one toward the measurement.
  always_comb begin
    next_newRef = newRef;
    if (start) begin
      next_newRef = diff[10] ? oldRef + quot : oldRef - quot; // RL13
    end
  end

  // Registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      newRef <= '0;
      done <= 1'b0;
    end else if (clkEn) begin
      newRef <= next_newRef;
      done <= start;
    end
  end

  chk_avg_between: assert property (@(posedge clk) disable iff (!rst_n) // RL13
    (start && clkEn) |=> (($past(diff) >= 0) ?
      (newRef <= $past(oldRef) && newRef >= {$past(meas), 2'h0}) :
      (newRef >= $past(oldRef) && newRef <= {$past(meas), 2'h0})))
    else $error("Average left the range between reference and measurement.");
endmodule

/* wcd_detect_top.sv */
// Low-power card presence detection sequencer.
`timescale 1ns/1ps
module wcd_detect_top
  import wcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic rcTick,
  input wire logic setDefault,
  input wire logic [7:0] opControl,
  input wire logic [7:0] wakeTimerCfg,
  input wire logic [7:0] ampCfg,
  input wire logic [7:0] phaseCfg,
  input wire logic [7:0] capCfg,
  input wire logic [7:0] ampHostRef,
  input wire logic [7:0] phaseHostRef,
  input wire logic [7:0] capHostRef,
  input wire logic adcValid,
  input wire logic [7:0] adcData,
  output logic fieldEnable,
  output logic measStart,
  output logic [1:0] measMethod,
  output logic detectActive,
  output logic wakeIrq,
  output logic [2:0] triggerFlags,
  output logic [7:0] ampAvgDisplay,
  output logic [7:0] phaseAvgDisplay,
  output logic [7:0] capAvgDisplay,
  output logic [7:0] ampResult,
  output logic [7:0] phaseResult,
  output logic [7:0] capResult
);
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  wcd_state_t state;
  wcd_state_t next_state;
  logic [2:0] pending;
  logic [2:0] next_pending;
  logic [FCNT_W-1:0] fieldCnt;
  logic [FCNT_W-1:0] next_fieldCnt;
  logic [7:0] meas;
  logic [7:0] next_meas;
  logic gotMeas;
  logic next_gotMeas;
  logic [1:0] next_measMethod;
  logic next_measStart;
  logic next_wakeIrq;
  logic [2:0] next_triggerFlags;
  logic modeRequest;
  logic timerRestart;
  logic timerExpire;
  logic [7:0] cfg [NUM_METHODS];
  logic [7:0] hostRef [NUM_METHODS];
  logic [9:0] avgRef [NUM_METHODS];
  logic [7:0] result [NUM_METHODS];
  logic [NUM_METHODS-1:0] initDone;
  logic [7:0] curCfg;
  logic [7:0] refUsed;
  logic [8:0] diff9;
  logic [7:0] absDiff;
  logic trigNow;
  logic avgStart;
  logic [9:0] avgNew;
  logic avgDone;
  logic [1:0] lowest;

  // ----------------------------------------------------------------------
  // Per-method configuration and display ports
  // ----------------------------------------------------------------------
  // Method index 0 is amplitude, 1 phase, 2 capacitive.
  assign cfg[M_AMP] = ampCfg; // RL8
  assign cfg[M_PHASE] = phaseCfg;
  assign cfg[M_CAP] = capCfg;
  assign hostRef[M_AMP] = ampHostRef;
  assign hostRef[M_PHASE] = phaseHostRef;
  assign hostRef[M_CAP] = capHostRef;
  // Average displays show the upper eight of the ten averaging bits.
  assign ampAvgDisplay = avgRef[M_AMP][9:2];
  assign phaseAvgDisplay = avgRef[M_PHASE][9:2];
  assign capAvgDisplay = avgRef[M_CAP][9:2];
  assign ampResult = result[M_AMP];
  assign phaseResult = result[M_PHASE];
  assign capResult = result[M_CAP];

  // ----------------------------------------------------------------------
  // Mode request and status decode
  // ----------------------------------------------------------------------
  // The mode is requested only when the request bit is the only bit set.
  assign modeRequest = (opControl == OPC_DETECT_ONLY); // RL1
  assign detectActive = (state != ST_IDLE);
  // The field is on only during the short window of a field measurement.
  assign fieldEnable = (state == ST_FIELD); // RL5

  // ----------------------------------------------------------------------
  // Reference selection and threshold compare
  // ----------------------------------------------------------------------
  assign curCfg = cfg[measMethod];
  // Either the running average or the host value is the reference.
  assign refUsed = curCfg[CFG_AUTO_BIT] ? avgRef[measMethod][9:2] : hostRef[measMethod]; // RL10
  assign diff9 = {1'b0, meas} - {1'b0, refUsed};
  assign absDiff = diff9[8] ? 8'(-diff9) : diff9[7:0]; // RL19
  // Trigger only when the difference is strictly above the threshold.
  assign trigNow = absDiff > {4'h0, curCfg[CFG_THR_LSB +: 4]}; // RL9 RL11
  // A triggering measurement enters the average only when its bit allows.
  assign avgStart = (state == ST_CMP) && curCfg[CFG_AUTO_BIT]
    && (!trigNow || curCfg[CFG_INCL_BIT]); // RL16
  // Lowest enabled method still to run in this period.
  assign lowest = pending[0] ? M_AMP : (pending[1] ? M_PHASE : M_CAP);
  assign timerRestart = (state == ST_IDLE) || (state == ST_PICK && pending == 3'h0);

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  wcd_interval_timer uTimer (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .rcTick(rcTick),
    .restart(timerRestart),
    .longStep(wakeTimerCfg[WTC_LONG_BIT]),
    .code(wakeTimerCfg[WTC_CODE_LSB +: 3]),
    .expire(timerExpire)
  );

  wcd_avg_unit uAvg (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .start(avgStart),
    .oldRef(avgRef[measMethod]),
    .meas(meas),
    .weightSel(curCfg[CFG_WEIGHT_LSB +: 2]),
    .newRef(avgNew),
    .done(avgDone)
  );

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Runs each enabled method in turn after an expiry seen in ST_WAIT, then restarts.
  always_comb begin
    next_state = state;
    next_pending = pending;
    next_fieldCnt = fieldCnt;
    next_meas = meas;
    next_gotMeas = gotMeas;
    next_measMethod = measMethod;
    next_measStart = 1'b0;
    next_wakeIrq = 1'b0;
    next_triggerFlags = triggerFlags;
    case (state)
      ST_IDLE: begin
        if (modeRequest) begin // RL1
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (timerExpire) begin // RL4
          next_pending = wakeTimerCfg[2:0]; // RL6
          next_triggerFlags = 3'h0;
          next_state = ST_PICK;
        end
      end
      ST_PICK: begin
        if (pending == 3'h0) begin
          // Period done: raise the interrupt if any method triggered.
          next_wakeIrq = |triggerFlags; // RL4
          next_state = ST_WAIT; // RL18
        end else begin
          next_measMethod = lowest;
          next_pending = pending & ~(3'h1 << lowest);
          next_measStart = 1'b1;
          next_gotMeas = 1'b0;
          next_fieldCnt = FCNT_W'(FIELD_CYC - 1);
          // Capacitive sensing needs no field; the others use a short one.
          next_state = (lowest == M_CAP) ? ST_CONV : ST_FIELD; // RL2
        end
      end
      ST_FIELD: begin
        if (adcValid) begin
          next_meas = adcData; // RL17
          next_gotMeas = 1'b1;
        end
        if (fieldCnt == '0) begin
          next_state = (gotMeas || adcValid) ? ST_INIT : ST_CONV;
        end else begin
          next_fieldCnt = fieldCnt - 10'h1; // RL5
        end
      end
      ST_CONV: begin
        if (adcValid) begin
          next_meas = adcData;
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        next_state = ST_CMP;
      end
      ST_CMP: begin
        if (trigNow) begin
          next_triggerFlags = triggerFlags | (3'h1 << measMethod);
        end
        next_state = avgStart ? ST_AVG : ST_PICK;
      end
      ST_AVG: begin
        if (avgDone) begin
          next_state = ST_PICK;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // Leaving the mode abandons any measurement, drops the field and starts nothing new.
    if (!modeRequest) begin
      next_state = ST_IDLE;
      next_measStart = 1'b0;
      next_wakeIrq = 1'b0;
    end
  end

  // Sequencer registers.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      pending <= 3'h0;
      fieldCnt <= '0;
      meas <= 8'h00;
      gotMeas <= 1'b0;
      measMethod <= M_AMP;
      measStart <= 1'b0;
      wakeIrq <= 1'b0;
      triggerFlags <= 3'h0;
    end else if (clkEn) begin
      state <= next_state;
      pending <= next_pending;
      fieldCnt <= next_fieldCnt;
      meas <= next_meas;
      gotMeas <= next_gotMeas;
      measMethod <= next_measMethod;
      measStart <= next_measStart;
      wakeIrq <= next_wakeIrq;
      triggerFlags <= next_triggerFlags;
    end
  end

  // ----------------------------------------------------------------------
  // Per-method reference and result state
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < NUM_METHODS; i++) begin : gMethod
    logic [9:0] next_avgRef;
    logic [7:0] next_result;
    logic next_initDone;
    logic sel;

    assign sel = (measMethod == 2'(i));

    // Seed the average once, then track it after each measurement that enters the average.
    always_comb begin
      next_avgRef = avgRef[i];
      next_result = result[i];
      next_initDone = initDone[i];
      // A seeding in the same cycle as the forget command wins over it.
      if (setDefault) begin
        next_initDone = 1'b0;
      end
      if (state == ST_INIT && sel) begin
        next_result = meas; // RL18
        if (!initDone[i]) begin
          next_avgRef = (hostRef[i] != 8'h00) ? {hostRef[i], 2'h0} : {meas, 2'h0}; // RL15
          next_initDone = 1'b1;
        end
      end
      if (state == ST_AVG && sel && avgDone) begin
        next_avgRef = avgNew; // RL13
      end
    end

    // Registers.
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        avgRef[i] <= 10'h000;
        result[i] <= 8'h00;
        initDone[i] <= 1'b0;
      end else if (clkEn) begin
        avgRef[i] <= next_avgRef;
        result[i] <= next_result;
        initDone[i] <= next_initDone;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Cycles of field on, counted only on enabled edges.
  logic [FCNT_W:0] fieldLen;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fieldLen <= '0;
    end else if (clkEn) begin
      fieldLen <= fieldEnable ? fieldLen + 11'h1 : 11'h0;
    end
  end

  chk_mode_exit: assert property (@(posedge clk) disable iff (!rst_n) // RL1
    (clkEn && !modeRequest) |=> (state == ST_IDLE && !fieldEnable))
    else $error("Sequencer stayed active without a clean request.");
  chk_field_short: assert property (@(posedge clk) disable iff (!rst_n) // RL5
    fieldEnable |-> (fieldLen < 11'(FIELD_CYC)))
    else $error("Reader field stayed on too long.");
  chk_cap_nofield: assert property (@(posedge clk) disable iff (!rst_n) // RL2
    (measStart && measMethod == M_CAP) |-> !fieldEnable)
    else $error("Field was switched on for a capacitive measurement.");
  chk_only_enabled: assert property (@(posedge clk) disable iff (!rst_n) // RL6
    measStart |-> wakeTimerCfg[measMethod])
    else $error("A disabled method was measured.");
  chk_irq_cause: assert property (@(posedge clk) disable iff (!rst_n) // RL9
    wakeIrq |-> (triggerFlags != 3'h0 && state == ST_WAIT))
    else $error("Interrupt without a triggered method.");
  chk_trig_excluded: assert property (@(posedge clk) disable iff (!rst_n) // RL16
    (state == ST_CMP && trigNow && !curCfg[CFG_INCL_BIT]) |-> !avgStart)
    else $error("Triggering measurement entered the average.");
  chk_result_shown: assert property (@(posedge clk) disable iff (!rst_n) // RL18
    (clkEn && state == ST_INIT) |=> (result[measMethod] == $past(meas)))
    else $error("Result display not updated with the measurement.");
  chk_seed_host: assert property (@(posedge clk) disable iff (!rst_n) // RL15
    (clkEn && state == ST_INIT && !initDone[measMethod]
      && hostRef[measMethod] != 8'h00)
    |=> (avgRef[measMethod] == {$past(hostRef[measMethod]), 2'h0}))
    else $error("Average not seeded from the host reference.");
endmodule

/* wcd_adc_model.sv */
// Measurement converter model that answers each measurement start.
`timescale 1ns/1ps
module wcd_adc_model
  import wcd_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic measStart,
  input wire logic [1:0] measMethod,
  input wire logic [7:0] ampVal,
  input wire logic [7:0] phaseVal,
  input wire logic [7:0] capVal,
  input wire logic [9:0] delay,
  output logic adcValid,
  output logic [7:0] adcData
);
  int cnt = -1;
  logic [7:0] held = 8'h00;

  // Outputs are defined from time zero.
  initial begin
    adcValid = 1'b0;
    adcData = 8'h00;
  end

  // Picks the value of the started method and answers after the set delay.
  always @(posedge clk) begin
    adcValid <= 1'b0;
    adcData <= ~adcData; // Stale data flips every cycle.
    if (!rst_n) begin
      cnt <= -1;
    end else if (measStart) begin
      held <= (measMethod == M_AMP) ? ampVal : (measMethod == M_PHASE) ? phaseVal : capVal;
      cnt <= int'(delay);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end else if (cnt == 0) begin
      adcValid <= 1'b1;
      adcData <= held;
      cnt <= -1;
    end
  end
endmodule

/* test_wakeup_card_presence_detect.sv */
// Self-checking bench for the card presence detection sequencer.
`timescale 1ns/1ps
module test_wakeup_card_presence_detect
  import wcd_pkg::*;
();
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  typedef struct packed {
    logic irq;
    logic [2:0] flags;
    logic [5:0] seq;
    logic [23:0] res;
    logic [23:0] avg;
    logic [2:0] chk;
  } wcd_note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1;
  logic rcTick = 1'b0;
  logic setDefault = 1'b0;
  logic [7:0] opControl = 8'h00;
  logic [7:0] wakeTimerCfg = 8'h00;
  logic [9:0] delay = 10'h005;
  logic [7:0] cfg [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] host [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] val [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] resM [3] = '{8'h00, 8'h00, 8'h00};
  logic [9:0] avgM [3] = '{10'h000, 10'h000, 10'h000};
  logic seeded [3] = '{1'b0, 1'b0, 1'b0};
  logic [7:0] refusedOps [4] = '{8'h05, 8'h84, 8'h0C, 8'h06};
  logic [7:0] phaseVals [3] = '{8'h69, 8'h5E, 8'h6A};
  logic [7:0] avgD [3];
  logic [7:0] res [3];
  logic fieldEnable, measStart, detectActive, wakeIrq, adcValid;
  logic [1:0] measMethod;
  logic [2:0] triggerFlags;
  logic [7:0] adcData;
  logic [31:0] rng = 32'h39B4;
  logic [5:0] seqSeen = 6'h00;
  logic irqSeen = 1'b0;
  logic pend = 1'b0;
  int quiet = 0;
  int fieldLen = 0;
  int periods = 0;
  int badCount = 0;
  int numChecks = 0;
  wcd_note_t notes [$];
  wcd_note_t cur;

  // Clock of 25 ns and an RC tick on every other cycle.
  always #12.5 clk = ~clk;
  always @(posedge clk) rcTick <= #2 ~rcTick;

  wcd_detect_top DUT (
    .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .rcTick(rcTick), .setDefault(setDefault),
    .opControl(opControl), .wakeTimerCfg(wakeTimerCfg), .ampCfg(cfg[0]),
    .phaseCfg(cfg[1]), .capCfg(cfg[2]), .ampHostRef(host[0]), .phaseHostRef(host[1]),
    .capHostRef(host[2]), .adcValid(adcValid), .adcData(adcData),
    .fieldEnable(fieldEnable), .measStart(measStart), .measMethod(measMethod),
    .detectActive(detectActive), .wakeIrq(wakeIrq), .triggerFlags(triggerFlags),
    .ampAvgDisplay(avgD[0]), .phaseAvgDisplay(avgD[1]), .capAvgDisplay(avgD[2]),
    .ampResult(res[0]), .phaseResult(res[1]), .capResult(res[2]));

  wcd_adc_model adcModel (
    .clk(clk), .rst_n(rst_n), .measStart(measStart), .measMethod(measMethod),
    .ampVal(val[0]), .phaseVal(val[1]), .capVal(val[2]), .delay(delay),
    .adcValid(adcValid), .adcData(adcData));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input logic [47:0] seen, input logic [47:0] want, input string what);
    numChecks++;
    if (seen !== want) begin
      badCount++;
      $display("[FAIL] %0t %s: saw %0h expected %0h", $time, what, seen, want);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  task automatic testDone();
    $display("Checks %0d, mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Works out one period's outcome for the enabled methods and queues it.
  task automatic predict(input logic [2:0] mask);
    wcd_note_t n;
    int d;
    logic trig;
    logic [7:0] rf;
    n = '0;
    for (int m = 0; m < 3; m++) begin
      if (mask[m]) begin
        if (!seeded[m]) begin
          avgM[m] = (host[m] != 8'h00) ? {host[m], 2'b00} : {val[m], 2'b00};
          seeded[m] = 1'b1;
        end
        rf = cfg[m][CFG_AUTO_BIT] ? avgM[m][9:2] : host[m];
        d = int'(val[m]) - int'(rf);
        if (d < 0) d = -d;
        trig = d > int'(cfg[m][CFG_THR_LSB +: 4]);
        if (cfg[m][CFG_AUTO_BIT] && (!trig || cfg[m][CFG_INCL_BIT]))
          avgM[m] = 10'(int'(avgM[m]) - (int'(avgM[m]) - int'({val[m], 2'b00}))
                    / (2 << cfg[m][CFG_WEIGHT_LSB +: 2]));
        resM[m] = val[m];
        n.flags[m] = trig;
        n.seq = {n.seq[3:0], 2'(m)};
      end
    end
    n.irq = |n.flags;
    n.res = {resM[2], resM[1], resM[0]};
    n.avg = {avgM[2][9:2], avgM[1][9:2], avgM[0][9:2]};
    n.chk = {cfg[2][CFG_AUTO_BIT], cfg[1][CFG_AUTO_BIT], cfg[0][CFG_AUTO_BIT]};
    notes.push_back(n);
  endtask

  // Enters detection, lets nPer periods pass and leaves again.
  task automatic run(input logic [7:0] wtc, input int nPer, input bit rnd);
    int k;
    int cyc;
    int tg;
    wakeTimerCfg = wtc;
    tg = (int'(wtc[6:4]) + 1) * (wtc[WTC_LONG_BIT] ? TICKS_LONG : TICKS_SHORT);
    for (int p = 0; p < nPer; p++) begin
      if (rnd) begin
        for (int m = 0; m < 3; m++) begin
          rng = xs(rng);
          val[m] = rng[7:0];
        end
        delay = 10'(rng[17:8] % 10'd900 + 10'd1);
      end
      predict(wtc[2:0]);
      k = periods;
      cyc = 0;
      if (p == 0) begin
        opControl = OPC_DETECT_ONLY;
        while (measStart !== 1'b1 && cyc < 60000) begin
          step(1);
          cyc++;
        end
        check(cyc / 2 >= tg - 2 && cyc / 2 <= tg + 2, 1, "interval");
      end
      while (periods == k && cyc < 70000) begin
        step(1);
        cyc++;
      end
      check(periods != k, 1, "period end");
    end
    opControl = 8'h00;
    step(2);
    check(detectActive, 0, "leave mode");
  endtask

  // Gathers each period's outputs and compares them with the oldest note.
  always @(negedge clk) begin
    if (measStart === 1'b1) begin
      seqSeen = {seqSeen[3:0], measMethod};
      quiet = 0;
      pend = 1'b0;
    end else if (pend && fieldEnable !== 1'b1) begin
      quiet++;
    end
    if (fieldEnable === 1'b1) begin
      fieldLen++;
    end else if (fieldLen != 0) begin
      check(fieldLen, FIELD_CYC, "field time");
      fieldLen = 0;
    end
    if (wakeIrq === 1'b1) irqSeen = 1'b1;
    if (adcValid === 1'b1) pend = 1'b1;
    if (quiet == 12) begin
      check(notes.size() != 0, 1, "unexpected period");
      if (notes.size() != 0) cur = notes.pop_front();
      check(irqSeen, cur.irq, "interrupt");
      check(triggerFlags, cur.flags, "trigger flags");
      check(seqSeen, cur.seq, "method order");
      for (int m = 0; m < 3; m++) begin
        check(res[m], cur.res[8 * m +: 8], "result display");
        if (cur.chk[m]) check(avgD[m], cur.avg[8 * m +: 8], "average display");
      end
      seqSeen = 6'h00;
      irqSeen = 1'b0;
      pend = 1'b0;
      quiet = 0;
      periods++;
    end
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    step(3);
    rst_n = 1'b1;
    step(1);
    check({fieldEnable, measStart, detectActive, wakeIrq, triggerFlags}, 0, "reset");
    check({avgD[0], avgD[1], avgD[2], res[0], res[1], res[2]}, 0, "reset displays");
    // A request made while the clock enable is low must not be taken.
    clkEn = 1'b0;
    opControl = OPC_DETECT_ONLY;
    step(4);
    check(detectActive, 0, "request while frozen");
    clkEn = 1'b1;
    wakeTimerCfg = 8'h07;
    foreach (refusedOps[i]) begin
      opControl = refusedOps[i];
      step(800);
      check(detectActive, 0, "refused request");
    end
    opControl = 8'h00;
    host = '{8'h40, 8'h64, 8'h00};
    cfg = '{8'h33, 8'h50, 8'h2F};
    val = '{8'h40, 8'h00, 8'h90};
    run(WTC_RESET | 8'h01, 1, 1'b0);
    val[0] = 8'h47;
    run(8'h01, 1, 1'b0);
    run(8'h04, 1, 1'b0);
    val[2] = 8'hA0;
    run(8'h34, 1, 1'b0);
    foreach (phaseVals[i]) begin
      val[1] = phaseVals[i];
      run(8'h02, 1, 1'b0);
    end
    repeat (3) begin
      setDefault = 1'b1;
      step(1);
      setDefault = 1'b0;
      seeded = '{1'b0, 1'b0, 1'b0};
      for (int m = 0; m < 3; m++) begin
        rng = xs(rng);
        cfg[m] = rng[7:0];
        host[m] = (m == 0) ? 8'h00 : rng[15:8];
      end
      run(8'h07, 4, 1'b1);
    end
    testDone();
  end

  // Cuts a hang short well beyond the planned run length.
  initial begin
    #(25 * 100000);
    badCount++;
    testDone();
  end
endmodule
